// ### ovr_map.vh
`ifndef OVR_MAP_VH
`define OVR_MAP_VH

// register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_THRESH 12'h004
`define ADDR_OVR_CFG 12'h008
`define ADDR_INSEL 12'h00C
`define ADDR_CAL 12'h010
`define ADDR_IRQ_STATUS 12'h014
`define ADDR_IRQ_CLEAR 12'h018
`define ADDR_IRQ_ENABLE 12'h01C
`define ADDR_FLAGS 12'h020

// offset trims: register indices, byte address is four times the index
`define IDX_TRIM_FIRST 10'h344
`define IDX_TRIM_LAST 10'h34A

// trim slots counted up from the first index
`define TRIM_A_ZERO 3'h0
`define TRIM_A_NINETY 3'h2
`define TRIM_B 3'h4

// field positions
`define CTRL_MODE_LSB 0
`define THR_HIGH_LSB 0
`define THR_LOW_LSB 8
`define PULSE_LENGTH_SETTING_LSB 0
`define INSEL_PEND_LSB 0
`define INSEL_ACT_LSB 4
`define CAL_START_BIT 0
`define CAL_FG_BIT 1
`define FLAGS_DES_BIT 4

// output mode bits
`define MODE_SINGLE_BIT 0
`define MODE_COMPLEX_BIT 1

// input select codes
`define INSEL_A 2'h0
`define INSEL_B 2'h1
`define INSEL_DUAL 2'h2

// reset values
`define RST_MODE 2'h0
`define RST_THR_HIGH 8'hE4
`define RST_THR_LOW 8'h40
`define RST_PULSE_LENGTH_SETTING 3'h0
`define RST_INSEL 2'h0
`define RST_FG 1'b1
`define RST_TRIM 8'h00

// timing counts
`define FLAG_MIN_CYCLES 11'h008
`define WIN_MIN_SAMPLES 8'h01

`endif

// ### ovr_stretch.v
`timescale 1ns/1ps
`default_nettype none
`include "ovr_map.vh"

module ovr_stretch (
  // clock and control
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  // detection and length
  input wire hit,
  input wire [2:0] pulse_length_setting,
  // stretched flag
  output reg flag
);

  reg [9:0] cnt;
  wire [10:0] len_m1;

  assign len_m1 = (`FLAG_MIN_CYCLES << pulse_length_setting) - 11'h001;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
      cnt <= 10'h000;
    end else if (clk_en) begin
      if (hit) begin
        flag <= 1'b1;
        cnt <= len_m1[9:0];
      end else if (cnt != 10'h000) begin
        cnt <= cnt - 10'h001;
      end else begin
        flag <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### adc_overrange_detector.v
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ovr_map.vh"

module adc_overrange_detector (
  // clock, reset, freeze
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // converter samples, two's complement
  input wire [11:0] in_a_sample,
  input wire [11:0] in_b_sample,
  // complex decimator samples
  input wire [15:0] ddc_i_a,
  input wire [15:0] ddc_q_a,
  input wire [15:0] ddc_i_b,
  input wire [15:0] ddc_q_b,
  // overrange flags
  output wire flag_out_a0,
  output wire flag_out_a1,
  output wire flag_out_b0,
  output wire flag_out_b1,
  // core samples and output data
  output reg [11:0] core_a_sample,
  output reg [11:0] core_b_sample,
  output reg [15:0] out_i_a,
  output reg [15:0] out_q_a,
  output reg [15:0] out_i_b,
  output reg [15:0] out_q_b,
  // converter control
  output reg both_edge_sampling,
  output reg cal_start,
  output reg [7:0] core_a_offset_trim,
  output reg [7:0] core_b_offset_trim,
  // interrupt
  output reg irq
);

  function [7:0] mag8;
    input [11:0] s;
    reg [11:0] neg;
    begin
      neg = ~s + 12'h001;
      if (s == 12'h800)
        mag8 = 8'hFF;
      else if (s[11])
        mag8 = neg[10:3];
      else
        mag8 = s[10:3];
    end
  endfunction

  function is_single;
    input [1:0] m;
    begin
      is_single = m[`MODE_SINGLE_BIT];
    end
  endfunction

  function is_complex;
    input [1:0] m;
    begin
      is_complex = m[`MODE_COMPLEX_BIT];
    end
  endfunction

  function trim_hit;
    input [11:0] a;
    begin
      trim_hit = (a[11:2] >= `IDX_TRIM_FIRST) && (a[11:2] <= `IDX_TRIM_LAST);
    end
  endfunction

  reg [1:0] output_mode_setting;
  reg [7:0] high_threshold;
  reg [7:0] low_threshold;
  reg [2:0] pulse_length_setting;
  reg [1:0] sel_pending;
  reg [1:0] sel_active;
  reg fg_mode;
  reg [7:0] trim [0:6];
  reg [3:0] irq_status;
  reg [3:0] irq_enable;
  reg [3:0] flag_q;
  reg dp_pend;
  reg dp_write;
  reg [11:0] dp_addr;
  reg [11:0] next_core_a;
  reg [11:0] next_core_b;
  reg [31:0] rd_data;
  reg [3:0] next_status;
  wire single;
  wire addr_ph;
  wire wr;
  wire [9:0] tdiff;
  wire [2:0] tidx;
  wire [3:0] hit;
  wire [3:0] flag_w;
  wire [3:0] wr_clr;
  wire [1:0] emb_hi;
  wire [1:0] emb_lo;
  wire a_from_b;
  wire b_from_b;
  integer k;

  assign single = is_single(output_mode_setting);
  assign addr_ph = hsel & htrans[1] & hready;
  assign wr = dp_pend & dp_write;
  assign tdiff = dp_addr[11:2] - `IDX_TRIM_FIRST;
  assign tidx = tdiff[2:0];

  always @* begin
    next_core_a = in_a_sample;
    next_core_b = in_b_sample;
    // input selection only in single mode; per-core inputs otherwise
    if (single) begin
      case (sel_active)
        `INSEL_B: begin
          next_core_a = in_b_sample;
          next_core_b = in_b_sample;
        end
        `INSEL_DUAL: begin
          next_core_a = in_a_sample;
          next_core_b = in_b_sample;
        end
        default: begin
          next_core_a = in_a_sample;
          next_core_b = in_a_sample;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      core_a_sample <= 12'h000;
      core_b_sample <= 12'h000;
      both_edge_sampling <= 1'b0;
    end else if (clk_en) begin
      core_a_sample <= next_core_a;
      core_b_sample <= next_core_b;
      both_edge_sampling <= single;
    end
  end

  assign hit[0] = mag8(core_a_sample) >= high_threshold;
  assign hit[1] = mag8(core_a_sample) >= low_threshold;
  assign hit[2] = mag8(core_b_sample) >= high_threshold;
  assign hit[3] = mag8(core_b_sample) >= low_threshold;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : stretch
      ovr_stretch u_stretch (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .hit(hit[g]),
        .pulse_length_setting(pulse_length_setting),
        .flag(flag_w[g])
      );
    end
  endgenerate

  // receiver ORs a and b flags in single mode
  assign flag_out_a0 = flag_w[0];
  assign flag_out_a1 = flag_w[1];
  assign flag_out_b0 = flag_w[2];
  assign flag_out_b1 = flag_w[3];

  // embedded status windows, one per channel
  generate
    for (g = 0; g < 2; g = g + 1) begin : mon
      reg [7:0] cnt;
      reg acc_hi;
      reg acc_lo;
      reg lat_hi;
      reg lat_lo;
      wire ch_hi;
      wire ch_lo;
      wire [8:0] sum;
      wire [7:0] period;
      // single mode: both cores are one channel
      assign ch_hi = single ? (hit[0] | hit[2]) : hit[2 * g];
      assign ch_lo = single ? (hit[1] | hit[3]) : hit[2 * g + 1];
      // two samples per clock in single mode
      assign sum = {1'b0, cnt} + (single ? 9'h002 : 9'h001);
      assign period = `WIN_MIN_SAMPLES << pulse_length_setting;
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          cnt <= 8'h00;
          acc_hi <= 1'b0;
          acc_lo <= 1'b0;
          lat_hi <= 1'b0;
          lat_lo <= 1'b0;
        end else if (clk_en) begin
          if (sum >= {1'b0, period}) begin
            cnt <= 8'h00;
            lat_hi <= acc_hi | ch_hi;
            lat_lo <= acc_lo | ch_lo;
            acc_hi <= 1'b0;
            acc_lo <= 1'b0;
          end else begin
            cnt <= sum[7:0];
            acc_hi <= acc_hi | ch_hi;
            acc_lo <= acc_lo | ch_lo;
          end
        end
      end
      assign emb_hi[g] = lat_hi | acc_hi;
      assign emb_lo[g] = lat_lo | acc_lo;
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      out_i_a <= 16'h0000;
      out_q_a <= 16'h0000;
      out_i_b <= 16'h0000;
      out_q_b <= 16'h0000;
    end else if (clk_en) begin
      if (is_complex(output_mode_setting)) begin
        out_i_a <= {ddc_i_a[15:1], emb_hi[0]};
        out_q_a <= {ddc_q_a[15:1], emb_lo[0]};
        out_i_b <= {ddc_i_b[15:1], emb_hi[1]};
        out_q_b <= {ddc_q_b[15:1], emb_lo[1]};
      end else begin
        out_i_a <= ddc_i_a;
        out_q_a <= ddc_q_a;
        out_i_b <= ddc_i_b;
        out_q_b <= ddc_q_b;
      end
    end
  end

  // ahb: one wait state so read data leaves a flop
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      dp_pend <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
    end else if (clk_en) begin
      if (dp_pend) begin
        dp_pend <= 1'b0;
        hreadyout <= 1'b1;
        if (!dp_write)
          hrdata <= rd_data;
      end else if (addr_ph) begin
        dp_pend <= 1'b1;
        dp_write <= hwrite;
        dp_addr <= haddr[11:0];
        hreadyout <= 1'b0;
      end
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    if (dp_addr == `ADDR_CTRL) begin
      rd_data[`CTRL_MODE_LSB +: 2] = output_mode_setting;
    end else if (dp_addr == `ADDR_THRESH) begin
      rd_data[`THR_HIGH_LSB +: 8] = high_threshold;
      rd_data[`THR_LOW_LSB +: 8] = low_threshold;
    end else if (dp_addr == `ADDR_OVR_CFG) begin
      rd_data[`PULSE_LENGTH_SETTING_LSB +: 3] = pulse_length_setting;
    end else if (dp_addr == `ADDR_INSEL) begin
      rd_data[`INSEL_PEND_LSB +: 2] = sel_pending;
      rd_data[`INSEL_ACT_LSB +: 2] = sel_active;
    end else if (dp_addr == `ADDR_CAL) begin
      rd_data[`CAL_FG_BIT] = fg_mode;
    end else if (dp_addr == `ADDR_IRQ_STATUS) begin
      rd_data[3:0] = irq_status;
    end else if (dp_addr == `ADDR_IRQ_ENABLE) begin
      rd_data[3:0] = irq_enable;
    end else if (dp_addr == `ADDR_FLAGS) begin
      rd_data[3:0] = flag_w;
      rd_data[`FLAGS_DES_BIT] = both_edge_sampling;
    end else if (trim_hit(dp_addr)) begin
      rd_data[7:0] = trim[tidx];
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      output_mode_setting <= `RST_MODE;
      high_threshold <= `RST_THR_HIGH;
      low_threshold <= `RST_THR_LOW;
      pulse_length_setting <= `RST_PULSE_LENGTH_SETTING;
      sel_pending <= `RST_INSEL;
      sel_active <= `RST_INSEL;
      fg_mode <= `RST_FG;
      cal_start <= 1'b0;
      irq_enable <= 4'h0;
      for (k = 0; k < 7; k = k + 1)
        trim[k] <= `RST_TRIM;
    end else if (clk_en) begin
      cal_start <= 1'b0;
      if (wr) begin
        if (dp_addr == `ADDR_CTRL) begin
          output_mode_setting <= hwdata[`CTRL_MODE_LSB +: 2];
        end else if (dp_addr == `ADDR_THRESH) begin
          high_threshold <= hwdata[`THR_HIGH_LSB +: 8];
          low_threshold <= hwdata[`THR_LOW_LSB +: 8];
        end else if (dp_addr == `ADDR_OVR_CFG) begin
          pulse_length_setting <= hwdata[`PULSE_LENGTH_SETTING_LSB +: 3];
        end else if (dp_addr == `ADDR_INSEL) begin
          sel_pending <= hwdata[`INSEL_PEND_LSB +: 2];
        end else if (dp_addr == `ADDR_CAL) begin
          fg_mode <= hwdata[`CAL_FG_BIT];
          if (hwdata[`CAL_START_BIT]) begin
            cal_start <= 1'b1;
            sel_active <= sel_pending;
          end
        end else if (dp_addr == `ADDR_IRQ_ENABLE) begin
          irq_enable <= hwdata[3:0];
        end else if (trim_hit(dp_addr) && fg_mode) begin
          trim[tidx] <= hwdata[7:0];
        end
      end
    end
  end

  // core sources, for trim selection
  assign a_from_b = single && (sel_active == `INSEL_B);
  // code 3 behaves as input A, so only B, dual and per-core pick the B trim
  assign b_from_b = !single || (sel_active == `INSEL_B) ||
    (sel_active == `INSEL_DUAL);

  // software keeps a and b trims matched
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      core_a_offset_trim <= `RST_TRIM;
      core_b_offset_trim <= `RST_TRIM;
    end else if (clk_en) begin
      if (!fg_mode) begin
        core_a_offset_trim <= `RST_TRIM;
        core_b_offset_trim <= `RST_TRIM;
      end else begin
        core_a_offset_trim <= trim[(single ? `TRIM_A_NINETY : `TRIM_A_ZERO)
          + {2'h0, a_from_b}];
        core_b_offset_trim <= trim[`TRIM_B + {2'h0, b_from_b}];
      end
    end
  end

  // sticky flag-rise events; a rise beats a clear
  assign wr_clr = (wr && dp_addr == `ADDR_IRQ_CLEAR) ? hwdata[3:0] : 4'h0;

  always @* begin
    next_status = (irq_status & ~wr_clr) | (flag_w & ~flag_q);
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_q <= 4'h0;
      irq_status <= 4'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      flag_q <= flag_w;
      irq_status <= next_status;
      irq <= |(next_status & irq_enable);
    end
  end

endmodule
`default_nettype wire

// ### adc_overrange_detector_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ovr_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // samples, flags, control
  input wire logic [11:0] in_b_sample,
  input wire logic [11:0] core_b_sample,
  input wire logic flag_out_a0,
  input wire logic flag_out_b1,
  input wire logic both_edge_sampling,
  input wire logic cal_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire taken = hsel && htrans[1] && hready && clk_en;
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  bus_wait_a: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("transfer wait not one cycle");
  bus_idle_a: assert property (!taken && hreadyout |=> hreadyout)
    else $error("wait inserted without a transfer");
  flag_hold_a: assert property ($rose(flag_out_a0) |=> flag_out_a0[*7])
    else $error("flag a0 shorter than eight cycles");
  flag_fall_a: assert property (
    $fell(flag_out_b1) |-> $past(flag_out_b1, 8))
    else $error("flag b1 fell early");
  core_dual_a: assert property (
    !both_edge_sampling && $past(clk_en) && !$past(sys_rst) |->
    core_b_sample == $past(in_b_sample))
    else $error("core b not fed by input b");
  cal_pulse_a: assert property (cal_start && clk_en |=> !cal_start)
    else $error("calibration start longer than a cycle");
  cal_cause_a: assert property (
    cal_start && $past(clk_en) |-> !$past(hreadyout))
    else $error("calibration start without a write");
  cover property ($rose(flag_out_a0));
  cover property ($fell(flag_out_b1));
  cover property (cal_start);
endmodule
bind adc_overrange_detector ovr_checker i_ovr_checker (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .in_b_sample(in_b_sample), .core_b_sample(core_b_sample),
  .flag_out_a0(flag_out_a0), .flag_out_b1(flag_out_b1),
  .both_edge_sampling(both_edge_sampling), .cal_start(cal_start));
`default_nettype wire

// ### flag_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flag_monitor (
  // flags from the detector
  input wire logic flag_out_a0,
  input wire logic flag_out_a1,
  input wire logic flag_out_b0,
  input wire logic flag_out_b1,
  // combined status
  output logic high_status,
  output logic low_status
);
  assign high_status = flag_out_a0 | flag_out_b0;
  assign low_status = flag_out_a1 | flag_out_b1;
endmodule
`default_nettype wire

// ### tb_adc_overrange_detector.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovr_map.vh"
module tb_adc_overrange_detector;
  logic ref_clk, sys_rst, clk_en, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [11:0] in_a, in_b;
  wire hreadyout, hresp, irq, fa0, fa1, fb0, fb1, hi_st, lo_st;
  wire [31:0] hrdata;
  wire [11:0] ca, cb;
  wire [15:0] oia, oqa, oib, oqb;
  wire [7:0] tr_a, tr_b;
  int n_fail, total_checks, hicnt;
  logic [11:0] smp [6] = '{12'h400, 12'h3FF, 12'h07F,
    12'hF80, 12'h800, 12'hC00};
  logic [1:0] ex [6] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h3};
  adc_overrange_detector i_adc_overrange_detector (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .in_a_sample(in_a), .in_b_sample(in_b),
    .ddc_i_a(16'hAAAB), .ddc_q_a(16'h5554), .ddc_i_b(16'h0001),
    .ddc_q_b(16'h8001), .flag_out_a0(fa0), .flag_out_a1(fa1),
    .flag_out_b0(fb0), .flag_out_b1(fb1), .core_a_sample(ca),
    .core_b_sample(cb), .out_i_a(oia), .out_q_a(oqa), .out_i_b(oib),
    .out_q_b(oqb), .both_edge_sampling(), .cal_start(),
    .core_a_offset_trim(tr_a), .core_b_offset_trim(tr_b), .irq(irq));
  flag_monitor i_flag_monitor (.flag_out_a0(fa0), .flag_out_a1(fa1),
    .flag_out_b0(fb0), .flag_out_b1(fb1), .high_status(hi_st),
    .low_status(lo_st));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // counts every clock edge with flag a0 high; cleared only while a0 is low, so clearing never races it
  always @(posedge ref_clk) if (fa0 === 1'b1) hicnt <= hicnt + 1;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      complete_run;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // one converter sample on both inputs, then quiet
  task automatic hit(input logic [11:0] s);
    in_a <= s;
    in_b <= s;
    @(posedge ref_clk);
    in_a <= 12'h000;
    in_b <= 12'h000;
  endtask
  initial begin
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, in_a, in_b} = '0;
    clk_en = 1'b1;
    n_fail = 0;
    total_checks = 0;
    hicnt = 0;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    rchk("thr_rst", `ADDR_THRESH, {16'h0, `RST_THR_LOW, `RST_THR_HIGH});
    rchk("unmapped", 12'h0FC, 32'h0);
    chk("pass_i", oia, 32'hAAAB);
    bus(1'b1, `ADDR_THRESH, 32'h1080);
    for (int i = 0; i < 6; i++) begin
      hit(smp[i]);
      cyc(3);
      chk("a0", fa0, ex[i][1]);
      chk("a1", fa1, ex[i][0]);
      chk("b0", fb0, ex[i][1]);
      chk("b1", fb1, ex[i][0]);
      cyc(12);
    end
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, `ADDR_OVR_CFG, s);
      hicnt = 0;
      hit(12'h7FF);
      cyc((8 << s) + 10);
      chk("pulse", hicnt, 8 << s);
    end
    bus(1'b1, `ADDR_OVR_CFG, 32'h0);
    hicnt = 0;
    hit(12'h7FF);
    cyc(4);
    hit(12'h7FF);
    cyc(30);
    chk("reload", hicnt, 32'd13);
    // a frozen clock holds both the flag and its counter
    hicnt = 0;
    hit(12'h7FF);
    cyc(3);
    clk_en <= 1'b0;
    cyc(20);
    clk_en <= 1'b1;
    cyc(20);
    chk("freeze", hicnt, 32'd28);
    bus(1'b1, `ADDR_IRQ_CLEAR, 32'hF);
    rchk("st_clr", `ADDR_IRQ_STATUS, 32'h0);
    hit(12'h7FF);
    cyc(3);
    rchk("status", `ADDR_IRQ_STATUS, 32'hF);
    chk("masked", irq, 1'b0);
    bus(1'b1, `ADDR_IRQ_ENABLE, 32'h1);
    cyc(1);
    chk("irq_on", irq, 1'b1);
    bus(1'b1, `ADDR_IRQ_CLEAR, 32'h1);
    rchk("st_one", `ADDR_IRQ_STATUS, 32'hE);
    chk("irq_off", irq, 1'b0);
    bus(1'b1, `ADDR_CTRL, 32'h2);
    in_a <= 12'h3FF;
    cyc(6);
    chk("i_a", oia, 32'hAAAA);
    chk("q_a", oqa, 32'h5555);
    chk("i_b", oib, 32'h0000);
    chk("q_b", oqb, 32'h8000);
    in_a <= 12'h000;
    cyc(12);
    chk("q_a_end", oqa, 32'h5554);
    bus(1'b1, `ADDR_CTRL, 32'h1);
    rchk("des", `ADDR_FLAGS, 32'h10);
    bus(1'b1, `ADDR_INSEL, 32'h1);
    rchk("pend", `ADDR_INSEL, 32'h01);
    bus(1'b1, `ADDR_CAL, 32'h3);
    rchk("act", `ADDR_INSEL, 32'h11);
    in_b <= 12'h123;
    cyc(3);
    chk("core_a", ca, 32'h123);
    chk("core_b", cb, 32'h123);
    // each core takes its own trim slot in single-channel mode from input B
    bus(1'b1, {`IDX_TRIM_FIRST + 10'h3, 2'b00}, 32'h5A);
    bus(1'b1, {`IDX_TRIM_FIRST + 10'h5, 2'b00}, 32'hC3);
    cyc(1);
    chk("trim_a", tr_a, 32'h5A);
    chk("trim_b", tr_b, 32'hC3);
    bus(1'b1, `ADDR_INSEL, 32'h2);
    bus(1'b1, `ADDR_CAL, 32'h3);
    in_a <= 12'h0AB;
    cyc(3);
    chk("dual_a", ca, 32'h0AB);
    chk("dual_b", cb, 32'h123);
    chk("dual_tr_a", tr_a, 32'h0);
    chk("dual_tr_b", tr_b, 32'hC3);
    bus(1'b1, `ADDR_CAL, 32'h0);
    cyc(1);
    chk("fg_off", tr_a, 32'h0);
    chk("fg_off_b", tr_b, 32'h0);
    rchk("trim_rb", {10'h347, 2'b00}, 32'h5A);
    hit(12'h7FF);
    cyc(3);
    chk("or_high", hi_st, 1'b1);
    chk("or_low", lo_st, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
